/* src/lds_pkg.sv */
// lds_pkg: register map, field positions, reset values, link timing and state codes
// for the led driver two-wire slave and its master.
// assumes: nothing; every design file that uses it refers to it as lds_pkg::name.
package lds_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] REG_RUN_CTRL   = 8'h00;
  localparam logic [7:0] REG_OPTIONS    = 8'h01;
  localparam logic [7:0] REG_GROUP_MODE = 8'h02;
  localparam logic [7:0] REG_GROUP_INT  = 8'h03;
  localparam logic [7:0] REG_MIX_FIRST  = 8'h04;
  localparam logic [7:0] REG_MIX_SECOND = 8'h05;
  localparam logic [7:0] REG_MIX_THIRD  = 8'h06;
  localparam logic [7:0] NUM_REGS       = 8'h07;

  // reset values
  localparam logic [7:0] RST_RUN_CTRL   = 8'h00;
  localparam logic [7:0] RST_OPTIONS    = 8'h3C;
  localparam logic [7:0] RST_GROUP_MODE = 8'h00;
  localparam logic [7:0] RST_GROUP_INT  = 8'hFF;
  localparam logic [7:0] RST_MIX        = 8'h00;

  // writable bits; the rest are reserved and read zero
  localparam logic [7:0] RUN_MASK       = 8'h40;
  localparam logic [7:0] OPT_MASK       = 8'h3F;

  // field positions
  localparam int CHIP_EN_BIT  = 6;
  localparam int OPT_LOG      = 5;
  localparam int OPT_PSAVE    = 4;
  localparam int OPT_AUTOINC  = 3;
  localparam int OPT_DITHER   = 2;
  localparam int OPT_MAXCUR   = 1;
  localparam int OPT_ALLOFF   = 0;

  // ==========================================================================
  // addressing
  localparam logic [4:0] ADDR_BASE  = 5'h0A;
  localparam logic [6:0] ADDR_BCAST = 7'h3C;

  // ==========================================================================
  // byte framing: bit counter values of the last data bit and of the acknowledge slot
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // ==========================================================================
  // link timing: least half period of the serial clock, rounded up
  localparam int CLK_HZ   = 100000000;
  localparam int LINK_HZ  = 400000;
  localparam int HALF_CYC = (CLK_HZ + 2 * LINK_HZ - 1) / (2 * LINK_HZ);

  // ==========================================================================
  // state codes
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_ADDR  = 3'b001,
    PH_INDEX = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100
  } lds_phase_t;

  typedef enum logic [3:0] {
    MS_IDLE   = 4'b0000,
    MS_STA_A  = 4'b0001,
    MS_STA_B  = 4'b0010,
    MS_BIT_LO = 4'b0011,
    MS_BIT_HI = 4'b0100,
    MS_ACK_LO = 4'b0101,
    MS_ACK_HI = 4'b0110,
    MS_RS_LO  = 4'b0111,
    MS_SP_LO  = 4'b1000,
    MS_SP_A   = 4'b1001,
    MS_SP_B   = 4'b1010
  } lds_mst_t;

endpackage : lds_pkg

/* src/lds_bus_if.sv */
// lds_bus_if: the two open-drain wires between master and device.
// assumes: pull-ups on both wires; a released or high-driven pin leaves the wire high.
`timescale 1ns/1ps
interface lds_bus_if;
  logic mstSclOut;
  logic mstSclOe_n;
  logic mstSdaOut;
  logic mstSdaOe_n;
  logic devSdaOut;
  logic devSdaOe_n;
  logic scl;
  logic sda;

  // ==========================================================================
  // wired-and resolution of the open-drain wires
  assign scl = mstSclOe_n | mstSclOut;
  assign sda = (mstSdaOe_n | mstSdaOut) & (devSdaOe_n | devSdaOut);

  modport dev (input scl, input sda, output devSdaOut, output devSdaOe_n);
  modport mst (input scl, input sda, output mstSclOut, output mstSclOe_n,
               output mstSdaOut, output mstSdaOe_n);
endinterface : lds_bus_if

/* src/lds_sync.sv */
// lds_sync: two flip-flop synchroniser for levels.
// assumes: din changes slowly against clk; only dout is read by the user.
`timescale 1ns/1ps
module lds_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // level in and out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // ==========================================================================
  // two stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : lds_sync

/* src/lds_device.sv */
// lds_device: two-wire slave of the led driver with its seven group registers.
// assumes: serial clock from lds_bus_if clocks the link logic; ref_clk clocks the
// system side; the master keeps its half of the bus protocol.
`timescale 1ns/1ps
module lds_device #(
  parameter int NMOD = 8
) (
  // link side
  lds_bus_if.dev                  bus,
  // system clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // address straps
  input  wire logic               strap_pin_high,
  input  wire logic               strap_pin_low,
  // per-module own settings
  input  wire logic [NMOD*8-1:0]  ownIntensity,
  input  wire logic [NMOD*24-1:0] ownMix,
  // effective settings
  output logic                    chipEnable,
  output logic [5:0]              optionBits,
  output logic [NMOD*8-1:0]       effIntensity,
  output logic [NMOD*24-1:0]      effMix
);

  // ==========================================================================
  // declarations
  logic                startTgl_q;
  logic                stopTgl_q;
  logic                startAck_q;
  logic                stopAck_q;
  logic [1:0]          strapSync;
  logic [7:0]          shift_q;
  logic                mAck_q;
  logic [3:0]          cnt_q;
  lds_pkg::lds_phase_t phase_q;
  logic                rdDir_q;
  logic [7:0]          index_q;
  logic [7:0]          tx_q;
  logic                sdaLvl_q;
  logic                updTgl_q;
  logic [7:0]          regs_q [7];
  logic                updSync;
  logic                updSeen_q;
  logic [7:0]          shRun_q;
  logic [7:0]          shOpt_q;
  logic [7:0]          shMode_q;
  logic [7:0]          shInt_q;
  logic [23:0]         shMix_q;

  // ==========================================================================
  // read and write helpers
  function automatic logic [7:0] rdReg(input logic [7:0] idx, input logic [7:0] r [7]);
    rdReg = (idx < lds_pkg::NUM_REGS) ? r[idx[2:0]] : 8'h00;
  endfunction : rdReg

  function automatic logic [7:0] wrMask(input logic [7:0] idx);
    if (idx == lds_pkg::REG_RUN_CTRL) wrMask = lds_pkg::RUN_MASK;
    else if (idx == lds_pkg::REG_OPTIONS) wrMask = lds_pkg::OPT_MASK;
    else if (idx < lds_pkg::NUM_REGS) wrMask = 8'hFF;
    else wrMask = 8'h00;
  endfunction : wrMask

  // ==========================================================================
  // frame conditions: data edges while the serial clock is high
  always_ff @(negedge bus.sda or posedge rst) begin
    if (rst) begin
      startTgl_q <= 1'b0;
    end else if (bus.scl) begin
      startTgl_q <= ~startTgl_q;
    end
  end

  always_ff @(posedge bus.sda or posedge rst) begin
    if (rst) begin
      stopTgl_q <= 1'b0;
    end else if (bus.scl) begin
      stopTgl_q <= ~stopTgl_q;
    end
  end

  wire startPend = startTgl_q ^ startAck_q;
  wire stopPend  = stopTgl_q ^ stopAck_q;

  // ==========================================================================
  // straps brought into the link domain
  lds_sync #(.WIDTH(2)) uStrapSync (
    .clk  (bus.scl),
    .rst  (rst),
    .din  ({strap_pin_high, strap_pin_low}),
    .dout (strapSync)
  );

  // ==========================================================================
  // decode of the received byte and the index walk
  wire [6:0] ownAddr  = {lds_pkg::ADDR_BASE, strapSync};
  wire [7:0] rxByte   = shift_q;
  wire       addrHit  = (rxByte[7:1] == ownAddr)
                      || (rxByte[7:1] == lds_pkg::ADDR_BCAST);
  wire [7:0] idxStep  = regs_q[1][lds_pkg::OPT_AUTOINC] ? 8'h01 : 8'h00;
  wire [7:0] nextIdx  = index_q + idxStep;
  wire [7:0] curData  = rdReg(index_q, regs_q);
  wire [7:0] nextData = rdReg(nextIdx, regs_q);
  wire [7:0] wrValue  = rxByte & wrMask(index_q);

  // ==========================================================================
  // rising clock edge: sample data and the master's answer
  always_ff @(posedge bus.scl or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
      mAck_q  <= 1'b0;
    end else begin
      shift_q <= {shift_q[6:0], bus.sda};
      if (cnt_q == lds_pkg::ACK_SLOT) begin
        mAck_q <= ~bus.sda;
      end
    end
  end

  // ==========================================================================
  // falling clock edge: byte sequencing, register writes, data drive
  always_ff @(negedge bus.scl or posedge rst) begin
    if (rst) begin
      startAck_q <= 1'b0;
      stopAck_q  <= 1'b0;
      cnt_q      <= 4'h0;
      phase_q    <= lds_pkg::PH_IDLE;
      rdDir_q    <= 1'b0;
      index_q    <= 8'h00;
      tx_q       <= 8'h00;
      sdaLvl_q   <= 1'b1;
      updTgl_q   <= 1'b0;
      regs_q[0]  <= lds_pkg::RST_RUN_CTRL;
      regs_q[1]  <= lds_pkg::RST_OPTIONS;
      regs_q[2]  <= lds_pkg::RST_GROUP_MODE;
      regs_q[3]  <= lds_pkg::RST_GROUP_INT;
      regs_q[4]  <= lds_pkg::RST_MIX;
      regs_q[5]  <= lds_pkg::RST_MIX;
      regs_q[6]  <= lds_pkg::RST_MIX;
    end else begin
      sdaLvl_q <= 1'b1;
      if (startPend) begin
        startAck_q <= startTgl_q;
        stopAck_q  <= stopTgl_q;
        cnt_q      <= 4'h0;
        phase_q    <= lds_pkg::PH_ADDR;
      end else if (stopPend || phase_q == lds_pkg::PH_IDLE) begin
        stopAck_q <= stopTgl_q;
        phase_q   <= lds_pkg::PH_IDLE;
      end else if (cnt_q == lds_pkg::LAST_BIT) begin
        cnt_q <= lds_pkg::ACK_SLOT;
        case (phase_q)
          lds_pkg::PH_ADDR: begin
            if (addrHit) begin
              sdaLvl_q <= 1'b0;
              rdDir_q  <= rxByte[0];
            end else begin
              phase_q <= lds_pkg::PH_IDLE;
            end
          end
          lds_pkg::PH_INDEX: begin
            index_q  <= rxByte;
            sdaLvl_q <= 1'b0;
          end
          lds_pkg::PH_WDATA: begin
            if (index_q < lds_pkg::NUM_REGS) begin
              regs_q[index_q[2:0]] <= wrValue;
            end
            updTgl_q <= ~updTgl_q;
            sdaLvl_q <= 1'b0;
          end
          default: begin
          end
        endcase
      end else if (cnt_q == lds_pkg::ACK_SLOT) begin
        cnt_q <= 4'h0;
        case (phase_q)
          lds_pkg::PH_ADDR: begin
            if (rdDir_q) begin
              phase_q  <= lds_pkg::PH_RDATA;
              tx_q     <= curData;
              sdaLvl_q <= curData[7];
            end else begin
              phase_q <= lds_pkg::PH_INDEX;
            end
          end
          lds_pkg::PH_INDEX: begin
            phase_q <= lds_pkg::PH_WDATA;
          end
          lds_pkg::PH_WDATA: begin
            index_q <= nextIdx;
          end
          default: begin
            if (mAck_q) begin
              index_q  <= nextIdx;
              tx_q     <= nextData;
              sdaLvl_q <= nextData[7];
            end else begin
              phase_q <= lds_pkg::PH_IDLE;
            end
          end
        endcase
      end else begin
        cnt_q <= cnt_q + 4'h1;
        if (phase_q == lds_pkg::PH_RDATA) begin
          sdaLvl_q <= tx_q[6];
          tx_q     <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // open drain data pin, low enable while pulling low
  assign bus.devSdaOut  = sdaLvl_q;
  assign bus.devSdaOe_n = sdaLvl_q;

  // ==========================================================================
  // system side: a write toggles, the toggle crosses, the stable registers are copied
  lds_sync #(.WIDTH(1)) uUpdSync (
    .clk  (ref_clk),
    .rst  (rst),
    .din  (updTgl_q),
    .dout (updSync)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      updSeen_q <= 1'b0;
      shRun_q   <= lds_pkg::RST_RUN_CTRL;
      shOpt_q   <= lds_pkg::RST_OPTIONS;
      shMode_q  <= lds_pkg::RST_GROUP_MODE;
      shInt_q   <= lds_pkg::RST_GROUP_INT;
      shMix_q   <= {3{lds_pkg::RST_MIX}};
    end else begin
      updSeen_q <= updSync;
      if (updSync != updSeen_q) begin
        shRun_q  <= regs_q[0];
        shOpt_q  <= regs_q[1];
        shMode_q <= regs_q[2];
        shInt_q  <= regs_q[3];
        shMix_q  <= {regs_q[6], regs_q[5], regs_q[4]};
      end
    end
  end

  // global controls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chipEnable <= 1'b0;
      optionBits <= lds_pkg::RST_OPTIONS[5:0];
    end else begin
      chipEnable <= shRun_q[lds_pkg::CHIP_EN_BIT];
      optionBits <= shOpt_q[5:0];
    end
  end

  // per-module choice between own and group settings
  wire [NMOD*8-1:0]  selInt;
  wire [NMOD*24-1:0] selMix;
  for (genvar m = 0; m < NMOD; m++) begin : gMod
    assign selInt[m*8 +: 8]   = shMode_q[m] ? shInt_q : ownIntensity[m*8 +: 8];
    assign selMix[m*24 +: 24] = shMode_q[m] ? shMix_q : ownMix[m*24 +: 24];
  end

  // one process owns both output vectors, so no variable has two writers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      effIntensity <= '0;
      effMix       <= '0;
    end else begin
      effIntensity <= selInt;
      effMix       <= selMix;
    end
  end

endmodule : lds_device

/* src/lds_master.sv */
// lds_master: two-wire bus master that writes or reads runs of device registers.
// assumes: ref_clk at 100 MHz; makes the serial clock by a divider; the device
// holds no clock low.
`timescale 1ns/1ps
module lds_master #(
  parameter int HALF = lds_pkg::HALF_CYC
) (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // link side
  lds_bus_if.mst     bus,
  // command
  input  wire logic       cmdValid,
  input  wire logic       cmdRead,
  input  wire logic [6:0] cmdAddr,
  input  wire logic [7:0] cmdIndex,
  input  wire logic [3:0] cmdCount,
  input  wire logic [7:0] cmdWData,
  output logic            cmdReady,
  // results
  output logic            wrTaken,
  output logic            rdValid,
  output logic [7:0]      rdData,
  output logic            done,
  output logic            nackSeen
);

  // ==========================================================================
  // declarations
  lds_pkg::lds_mst_t state_q;
  logic [15:0]       half_q;
  logic              sclLvl_q;
  logic              sdaLvl_q;
  logic [7:0]        tx_q;
  logic [7:0]        rx_q;
  logic [2:0]        bitCnt_q;
  logic [1:0]        byteNo_q;
  logic [3:0]        remain_q;
  logic              rd_q;
  logic              sending_q;
  logic [6:0]        addr_q;
  logic [7:0]        index_q;
  logic              sdaSync;
  logic              sdaOut_q;

  // ==========================================================================
  // data wire in through two flops
  lds_sync #(.WIDTH(1)) uSdaSync (
    .clk  (ref_clk),
    .rst  (rst),
    .din  (bus.sda),
    .dout (sdaSync)
  );

  // half period divider
  wire       tick    = (half_q == 16'(HALF - 1));
  wire       ackOk   = ~sdaSync;
  wire       lastOne = (remain_q == 4'h1);

  // ==========================================================================
  // divider, restarted in idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      half_q <= 16'h0000;
    end else begin
      half_q <= (tick || state_q == lds_pkg::MS_IDLE) ? 16'h0000 : half_q + 16'h0001;
    end
  end

  // ==========================================================================
  // bit and byte sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q   <= lds_pkg::MS_IDLE;
      sclLvl_q  <= 1'b1;
      sdaLvl_q  <= 1'b1;
      tx_q      <= 8'h00;
      rx_q      <= 8'h00;
      bitCnt_q  <= 3'h0;
      byteNo_q  <= 2'h0;
      remain_q  <= 4'h0;
      rd_q      <= 1'b0;
      sending_q <= 1'b0;
      addr_q    <= 7'h00;
      index_q   <= 8'h00;
      cmdReady  <= 1'b0;
      wrTaken   <= 1'b0;
      rdValid   <= 1'b0;
      rdData    <= 8'h00;
      done      <= 1'b0;
      nackSeen  <= 1'b0;
    end else begin
      wrTaken <= 1'b0;
      rdValid <= 1'b0;
      done    <= 1'b0;
      case (state_q)
        lds_pkg::MS_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady  <= 1'b0;
            rd_q      <= cmdRead;
            addr_q    <= cmdAddr;
            index_q   <= cmdIndex;
            remain_q  <= (cmdCount == 4'h0) ? 4'h1 : cmdCount;
            tx_q      <= {cmdAddr, 1'b0};
            sending_q <= 1'b1;
            byteNo_q  <= 2'h0;
            nackSeen  <= 1'b0;
            state_q   <= lds_pkg::MS_STA_A;
          end
        end
        default: begin
          if (tick) begin
            case (state_q)
              lds_pkg::MS_STA_A: begin
                sclLvl_q <= 1'b1;
                sdaLvl_q <= 1'b0;
                state_q  <= lds_pkg::MS_STA_B;
              end
              lds_pkg::MS_STA_B, lds_pkg::MS_ACK_LO, lds_pkg::MS_BIT_LO: begin
                sclLvl_q <= (state_q != lds_pkg::MS_STA_B);
                if (state_q == lds_pkg::MS_STA_B) begin
                  sdaLvl_q <= tx_q[7];
                  bitCnt_q <= 3'h0;
                end
                state_q <= (state_q == lds_pkg::MS_STA_B) ? lds_pkg::MS_BIT_LO
                         : (state_q == lds_pkg::MS_ACK_LO) ? lds_pkg::MS_ACK_HI
                         : lds_pkg::MS_BIT_HI;
              end
              lds_pkg::MS_BIT_HI: begin
                rx_q     <= {rx_q[6:0], sdaSync};
                sclLvl_q <= 1'b0;
                if (bitCnt_q == 3'h7) begin
                  sdaLvl_q <= sending_q | lastOne;
                  state_q  <= lds_pkg::MS_ACK_LO;
                end else begin
                  bitCnt_q <= bitCnt_q + 3'h1;
                  sdaLvl_q <= sending_q ? tx_q[6] : 1'b1;
                  tx_q     <= {tx_q[6:0], 1'b0};
                  state_q  <= lds_pkg::MS_BIT_LO;
                end
              end
              lds_pkg::MS_ACK_HI: begin
                sclLvl_q <= 1'b0;
                bitCnt_q <= 3'h0;
                if (sending_q && !ackOk) begin
                  nackSeen <= 1'b1;
                  sdaLvl_q <= 1'b0;
                  state_q  <= lds_pkg::MS_SP_LO;
                end else if (!sending_q) begin
                  rdValid  <= 1'b1;
                  rdData   <= rx_q;
                  remain_q <= remain_q - 4'h1;
                  sdaLvl_q <= ~lastOne;
                  state_q  <= lastOne ? lds_pkg::MS_SP_LO : lds_pkg::MS_BIT_LO;
                end else if (byteNo_q == 2'h0) begin
                  byteNo_q <= 2'h1;
                  tx_q     <= index_q;
                  sdaLvl_q <= index_q[7];
                  state_q  <= lds_pkg::MS_BIT_LO;
                end else if (rd_q && byteNo_q == 2'h1) begin
                  byteNo_q <= 2'h2;
                  tx_q     <= {addr_q, 1'b1};
                  sdaLvl_q <= 1'b1;
                  state_q  <= lds_pkg::MS_RS_LO;
                end else if (rd_q) begin
                  sending_q <= 1'b0;
                  sdaLvl_q  <= 1'b1;
                  state_q   <= lds_pkg::MS_BIT_LO;
                end else if (byteNo_q == 2'h2 && lastOne) begin
                  sdaLvl_q <= 1'b0;
                  state_q  <= lds_pkg::MS_SP_LO;
                end else begin
                  if (byteNo_q == 2'h2) begin
                    remain_q <= remain_q - 4'h1;
                  end
                  byteNo_q <= 2'h2;
                  wrTaken  <= 1'b1;
                  tx_q     <= cmdWData;
                  sdaLvl_q <= cmdWData[7];
                  state_q  <= lds_pkg::MS_BIT_LO;
                end
              end
              lds_pkg::MS_RS_LO: begin
                sclLvl_q <= 1'b1;
                state_q  <= lds_pkg::MS_STA_A;
              end
              lds_pkg::MS_SP_LO: begin
                sclLvl_q <= 1'b1;
                state_q  <= lds_pkg::MS_SP_A;
              end
              lds_pkg::MS_SP_A: begin
                sdaLvl_q <= 1'b1;
                state_q  <= lds_pkg::MS_SP_B;
              end
              default: begin
                done    <= 1'b1;
                state_q <= lds_pkg::MS_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // data pin lags one cycle: it never moves in the step where the clock falls,
  // so the far end cannot see a false start or stop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdaOut_q <= 1'b1;
    end else begin
      sdaOut_q <= sdaLvl_q;
    end
  end

  // open drain pins, low enable while pulling low
  assign bus.mstSclOut  = sclLvl_q;
  assign bus.mstSclOe_n = sclLvl_q;
  assign bus.mstSdaOut  = sdaOut_q;
  assign bus.mstSdaOe_n = sdaOut_q;

endmodule : lds_master

/* tb/lds_properties.sv */
// lds_properties: link checks on the resolved wires, sampled by ref_clk.
// assumes: serial half period of eight ref_clk cycles or more.
`timescale 1ns/1ps
module lds_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // wires and data enables
  input wire logic scl,
  input wire logic sda,
  input wire logic mstSdaOe_n,
  input wire logic devSdaOe_n,
  // straps
  input wire logic strap_pin_high,
  input wire logic strap_pin_low
);
  // ====================
  // bit position and first byte tracking
  logic       sclQ, sdaQ, firstQ;
  logic [3:0] cntQ;
  logic [7:0] srQ;
  wire        rise = scl & ~sclQ;
  wire        stop = scl & sclQ & ~sdaQ & sda;
  wire        sta = scl & sclQ & sdaQ & ~sda;
  wire        firstD = sta | (firstQ & ~stop & ~(rise & cntQ == 4'h9));
  wire [3:0]  stepD = (cntQ == 4'h9) ? 4'h1 : cntQ + 4'h1;
  wire [3:0]  cntD = (sta | stop) ? 4'h0 : rise ? stepD : cntQ;
  wire [7:0]  srD = (rise && cntQ < 4'h8) ? {srQ[6:0], sda} : srQ;
  wire        hit = srQ[7:1] == {lds_pkg::ADDR_BASE, strap_pin_high, strap_pin_low}
              || srQ[7:1] == lds_pkg::ADDR_BCAST;
  // sampling flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) {sclQ, sdaQ, firstQ, cntQ, srQ} <= {2'b11, 13'h0000};
    else {sclQ, sdaQ, firstQ, cntQ, srQ} <= {scl, sda, firstD, cntD, srD};
  end
  // ====================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(devSdaOe_n))
    else $error("device data moved");
  AST_ONE_DRIVER: assert property (scl |-> mstSdaOe_n || devSdaOe_n)
    else $error("both ends drive data");
  AST_ADDR_QUIET: assert property (firstQ && scl && sclQ && cntQ inside {[1:8]} |-> devSdaOe_n)
    else $error("device drove address bits");
  AST_ADDR_ACK: assert property (firstQ && scl && sclQ && cntQ == 4'h9 |-> devSdaOe_n == !hit)
    else $error("address acknowledge wrong");
  AST_MST_FREE: assert property (firstQ && scl && sclQ && cntQ == 4'h9 |-> mstSdaOe_n)
    else $error("master held acknowledge slot");
  AST_WR_FREE: assert property ($fell(scl) && firstQ && cntQ == 4'h9 && !srQ[0] |-> devSdaOe_n)
    else $error("device held data after ack");
  AST_CLK_PULSE: assert property ($rose(scl) |-> scl[*4])
    else $error("clock pulse short");
  AST_STOP_IDLE: assert property (stop |=> (scl && sda)[*4])
    else $error("bus not free after stop");
endmodule : lds_properties

/* tb/tb_led_driver_i2c_slave_regs.sv */
// tb_led_driver_i2c_slave_regs: register traffic from lds_master to lds_device.
// assumes: straps give own address 2Ah; master half period of 8 cycles.
`timescale 1ns/1ps
module tb_led_driver_i2c_slave_regs;
  logic         ref_clk = 1'b0, rst = 1'b0, cmdValid = 1'b0, cmdRead = 1'b0;
  logic         strap_pin_high = 1'b1, strap_pin_low = 1'b0;
  logic [6:0]   cmdAddr = 7'h00;
  logic [7:0]   cmdIndex = 8'h00, cmdWData = 8'h00, rdData;
  logic [3:0]   cmdCount = 4'h1;
  logic         cmdReady, wrTaken, rdValid, done, nackSeen, chipEnable;
  logic [5:0]   optionBits;
  logic [63:0]  ownIntensity = 64'h0123456789ABCDEF, effIntensity, wdat;
  logic [191:0] ownMix = {24{8'hC3}}, effMix;
  logic [7:0]   rq[$];
  int           n_errors = 0, n_checks = 0, wi = 0, cyc = 0;
  // ====================
  // both ends and the checker
  lds_bus_if bus ();
  lds_device lds_device_inst (.*);
  lds_master #(.HALF(8)) lds_master_inst (.*);
  lds_properties lds_properties_inst (.*, .scl(bus.scl), .sda(bus.sda),
    .mstSdaOe_n(bus.mstSdaOe_n), .devSdaOe_n(bus.devSdaOe_n));
  // clock
  initial forever #5 ref_clk = ~ref_clk;
  // next write byte, read capture and hang limit
  always @(negedge ref_clk) begin
    cyc++;
    if (wrTaken === 1'b1 && wi < 7) begin
      wi++;
      cmdWData = wdat[63-8*wi -: 8];
    end
    if (rdValid === 1'b1) rq.push_back(rdData);
    if (cyc == 30000) begin
      n_errors++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
    end
  end
  // ====================
  // tasks
  task chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: want %h got %h", $time, e, g);
    end
  endtask : chk
  task xfer(input logic r, input logic [6:0] a, input logic [7:0] i, input logic [3:0] n,
            input logic [63:0] d);
    rq.delete();
    wdat = d;
    wi = 0;
    repeat (2) @(negedge ref_clk);
    {cmdValid, cmdRead, cmdAddr, cmdIndex, cmdCount, cmdWData} = {1'b1, r, a, i, n, d[63:56]};
    @(negedge ref_clk);
    cmdValid = 1'b0;
    while (done !== 1'b1) @(negedge ref_clk);
  endtask : xfer
  task rdchk(input logic [6:0] a, input logic [7:0] i, input logic [3:0] n, input logic [63:0] e);
    xfer(1'b1, a, i, n, 64'h0);
    chk({4'h0, n}, 8'(rq.size()));
    for (int k = 0; k < n && k < rq.size(); k++) chk(e[63-8*k -: 8], rq[k]);
  endtask : rdchk
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ====================
  // tests
  initial begin
    #1 rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    rdchk(7'h2A, 8'h00, 4'h8, 64'h003C00FF00000000);
    $display("test reset values done");
    xfer(1'b0, 7'h3C, 8'h00, 4'h8, 64'hFFFF815A11223377);
    rdchk(7'h3C, 8'h00, 4'h8, 64'h403F815A11223300);
    chk(8'h01, {7'h0, chipEnable});
    chk(8'h3F, {2'b00, optionBits});
    chk(8'h5A, effIntensity[7:0]);
    chk(8'h33, effMix[23:16]);
    chk(8'hCD, effIntensity[15:8]);
    $display("test broadcast run done");
    xfer(1'b0, 7'h2A, 8'hFF, 4'h2, 64'hA500000000000000);
    rdchk(7'h2A, 8'hFF, 4'h3, 64'h00003F0000000000);
    chk(8'h00, {7'h0, chipEnable});
    $display("test index wrap done");
    xfer(1'b0, 7'h2A, 8'h01, 4'h1, 64'h3700000000000000);
    xfer(1'b0, 7'h2A, 8'h04, 4'h3, 64'h0102030000000000);
    rdchk(7'h2A, 8'h04, 4'h3, 64'h0303030000000000);
    rdchk(7'h2A, 8'h05, 4'h1, 64'h2200000000000000);
    $display("test fixed index done");
    xfer(1'b0, 7'h2B, 8'h00, 4'h1, 64'h0);
    chk(8'h01, {7'h0, nackSeen});
    $display("test foreign address done");
    complete_run();
  end
endmodule : tb_led_driver_i2c_slave_regs
